// ==== rtl/sar_ctrl_defines.svh ====
// Constants for the converter control block: offsets, fields, resets, timing.
// Assumes a 20 MHz system clock and a byte-addressed register port.
`ifndef SAR_CTRL_DEFINES_SVH
`define SAR_CTRL_DEFINES_SVH

`define ADDR_W          8
`define DATA_W          32
`define RES_W           12
`define MSB_TRIAL       12'h800

`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_RESULT      8'h08
`define OFF_IRQ_STAT    8'h0C
`define OFF_IRQ_MASK    8'h10
`define OFF_CLK_DIV     8'h14

`define CTRL_EN         0
`define CTRL_START      1
`define CTRL_ONE_SHOT   2
`define CTRL_DIFF       3
`define CTRL_W          4
`define CTRL_RESET      4'h4

`define STAT_READY      0
`define STAT_BUSY       1
`define STAT_DONE       2
`define STAT_W          3

`define EV_DONE         0
`define EV_READY        1
`define EV_OVERRUN      2
`define EV_W            3
`define EV_RESET        3'h0

`define DIV_W           4
`define DIV_RESET       4'h2
`define DIV_MIN         4'h2

`define CLK_PERIOD_NS   50
`define POWERUP_NS      10000
`define WARM_W          8
`define WARM_CYC        8'((`POWERUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SMP_W           2
`define SAMPLE_TICKS    2'h3

`endif

// ==== rtl/sar_ctrl_pkg.sv ====
// Types shared by the converter control block.
// Assumes the constants header sits on the include path.
package sar_ctrl_pkg;
	`include "sar_ctrl_defines.svh"

	typedef struct packed {
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wdata;
		logic               wr;
		logic               rd;
	} reg_req_type;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_WARMUP,
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT
	} state_type;
endpackage

// ==== rtl/conv_clk_div.sv ====
// Conversion clock enable generator derived from the system clock.
// Assumes the divisor register is written by software; values below 2 are raised.
`timescale 1ns/1ps
`include "sar_ctrl_defines.svh"
module conv_clk_div
	import sar_ctrl_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic [`DIV_W-1:0] div_val,
	output logic                   tick_q
);
	logic [`DIV_W-1:0] cnt_q;
	logic [`DIV_W-1:0] lim;

	// Floor of 2 keeps the conversion rate at 10 MHz or less
	assign lim = (div_val < `DIV_MIN) ? `DIV_MIN : div_val;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else if (cnt_q >= lim - `DIV_W'(1)) begin
			cnt_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + `DIV_W'(1);
			tick_q <= 1'b0;
		end
	end

	tick_spacing_a: assert property (@(posedge clk) disable iff (!resetn)
		tick_q |=> !tick_q) else $error("Conversion tick faster than half clk");
endmodule

// ==== rtl/sar_step_engine.sv ====
// Binary search engine: one result bit per conversion tick, MSB first.
// Assumes the comparator settles within one tick of a new trial code.
`timescale 1ns/1ps
`include "sar_ctrl_defines.svh"
module sar_step_engine
	import sar_ctrl_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              tick,
	input  wire logic              start,
	input  wire logic              cmp_hi,
	output logic [`RES_W-1:0]      dac_code_q,
	output logic [`RES_W-1:0]      result_q,
	output logic                   busy_q,
	output logic                   done_q
);
	logic [`RES_W-1:0] bit_q;

	function automatic logic [`RES_W-1:0] settle(input logic [`RES_W-1:0] code,
		input logic [`RES_W-1:0] trial, input logic hi);
		settle = hi ? code : (code & ~trial);
	endfunction

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bit_q      <= '0;
			dac_code_q <= '0;
			result_q   <= '0;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				busy_q     <= 1'b1;
				bit_q      <= `MSB_TRIAL;
				dac_code_q <= `MSB_TRIAL;
			end else if (busy_q && tick) begin
				if (bit_q[0]) begin
					result_q   <= settle(dac_code_q, bit_q, cmp_hi);
					dac_code_q <= settle(dac_code_q, bit_q, cmp_hi);
					busy_q     <= 1'b0;
					done_q     <= 1'b1;
				end else begin
					dac_code_q <= settle(dac_code_q, bit_q, cmp_hi) | (bit_q >> 1);
					bit_q      <= bit_q >> 1;
				end
			end
		end
	end

	msb_first_a: assert property (@(posedge clk) disable iff (!resetn)
		start |=> dac_code_q == `MSB_TRIAL && busy_q) else $error("Search not started at MSB");
	lsb_last_a: assert property (@(posedge clk) disable iff (!resetn)
		done_q |-> $past(bit_q[0]) && !busy_q) else $error("Search ended before LSB");
endmodule

// ==== rtl/sar_conv_ctrl.sv ====
// Converter control: register port, power-up wait, start sources, modes, done flag, interrupt.
// Assumes synchronous inputs, an analog comparator on cmp_hi and a DMA read acknowledge.
`timescale 1ns/1ps
`include "sar_ctrl_defines.svh"

// How it works
// - Each conversion yields a 12-bit result and the pacing allows rates up to one result per 15 ticks, about 667 ksps.
// - Single-ended or differential input is chosen by a control bit, held steady per conversion.
// - Result bits are resolved one at a time against the trial code, MSB first, LSB last.
// - A conversion starts on a software start bit or on a frame-start strobe.
// - Continuous mode runs with no frame-start strobe at all.
// - After power-up or wake the converter waits 10 us before it accepts a conversion.
// - On completion a status bit and the done output rise and stay until the result is read.
// - The done output is the DMA request; the interrupt comes from the sticky done event bit set on the same completion.
// - A mode bit picks continuous conversion or exactly one conversion per start.
// - In continuous mode DMA can move every result with no CPU action between samples.
module sar_conv_ctrl
	import sar_ctrl_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire reg_req_type       bus,
	output logic [`DATA_W-1:0]     rdata_q,
	input  wire logic              sof,
	input  wire logic              sleep,
	input  wire logic              cmp_hi,
	input  wire logic              dma_ack,
	output logic [`RES_W-1:0]      dac_code,
	output logic                   sample_q,
	output logic                   diff_sel_q,
	output logic                   eof_q,
	output logic                   irq_q
);
	state_type          state_q;
	logic               en_q;
	logic               one_shot_q;
	logic               diff_q;
	logic [`DIV_W-1:0]  div_q;
	logic [`EV_W-1:0]   istat_q;
	logic [`EV_W-1:0]   mask_q;
	logic [`RES_W-1:0]  result_q;
	logic [`WARM_W-1:0] warm_cnt_q;
	logic [`SMP_W-1:0]  smp_cnt_q;
	logic               ready_q;
	logic               sof_prev_q;
	logic               tick;
	logic               eng_busy;
	logic               eng_done;
	logic [`RES_W-1:0]  eng_result;
	logic               awake;
	logic               start_req;
	logic               eng_start;
	logic               conv_done;
	logic               res_rd;
	logic               ready_set;
	logic               overrun;
	logic [`EV_W-1:0]   events;

	// Named so single reset bits can be picked from it
	localparam logic [`CTRL_W-1:0] ctrl_init = `CTRL_RESET;

	function automatic logic hit(input reg_req_type r, input logic [`ADDR_W-1:0] off,
		input logic is_wr);
		hit = (is_wr ? r.wr : r.rd) && (r.addr == off);
	endfunction

	conv_clk_div u_div (
		.clk     (clk),
		.resetn  (resetn),
		.div_val (div_q),
		.tick_q  (tick)
	);

	sar_step_engine u_engine (
		.clk        (clk),
		.resetn     (resetn),
		.tick       (tick),
		.start      (eng_start),
		.cmp_hi     (cmp_hi),
		.dac_code_q (dac_code),
		.result_q   (eng_result),
		.busy_q     (eng_busy),
		.done_q     (eng_done)
	);

	assign awake     = en_q && !sleep;
	assign start_req = hit(bus, `OFF_CTRL, 1'b1) && bus.wdata[`CTRL_START]
		|| (sof && !sof_prev_q);
	assign eng_start = state_q == ST_SAMPLE && tick && smp_cnt_q == `SAMPLE_TICKS - `SMP_W'(1);
	// Results finishing after a power-down are dropped
	assign conv_done = eng_done && state_q == ST_CONVERT;
	assign res_rd    = hit(bus, `OFF_RESULT, 1'b0) || dma_ack;
	assign ready_set = state_q == ST_WARMUP && awake && warm_cnt_q == `WARM_CYC - `WARM_W'(1);
	assign overrun   = conv_done && eof_q && !res_rd;

	always_comb begin
		events              = `EV_RESET;
		events[`EV_DONE]    = conv_done;
		events[`EV_READY]   = ready_set;
		events[`EV_OVERRUN] = overrun;
	end

	// Control registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_q       <= ctrl_init[`CTRL_EN];
			one_shot_q <= ctrl_init[`CTRL_ONE_SHOT];
			diff_q     <= ctrl_init[`CTRL_DIFF];
			div_q      <= `DIV_RESET;
			mask_q     <= `EV_RESET;
		end else begin
			if (hit(bus, `OFF_CTRL, 1'b1)) begin
				en_q       <= bus.wdata[`CTRL_EN];
				one_shot_q <= bus.wdata[`CTRL_ONE_SHOT];
				diff_q     <= bus.wdata[`CTRL_DIFF];
			end
			if (hit(bus, `OFF_CLK_DIV, 1'b1))
				div_q <= bus.wdata[`DIV_W-1:0];
			if (hit(bus, `OFF_IRQ_MASK, 1'b1))
				mask_q <= bus.wdata[`EV_W-1:0];
		end
	end

	// Frame-start edge detect
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sof_prev_q <= 1'b0;
		else
			sof_prev_q <= sof;
	end

	// Power-up wait counter and ready flag
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			warm_cnt_q <= '0;
			ready_q    <= 1'b0;
		end else begin
			if (state_q == ST_WARMUP && awake)
				warm_cnt_q <= warm_cnt_q + `WARM_W'(1);
			else
				warm_cnt_q <= '0;
			if (!awake)
				ready_q <= 1'b0;
			else if (ready_set)
				ready_q <= 1'b1;
		end
	end

	// Sequencer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_OFF;
		end else if (!awake) begin
			state_q <= ST_OFF;
		end else begin
			unique case (state_q)
				ST_OFF: begin
					state_q <= ST_WARMUP;
				end
				ST_WARMUP: begin
					if (ready_set)
						state_q <= ST_IDLE;
				end
				ST_IDLE: begin
					// Continuous mode needs no strobe; early starts are simply ignored
					if (!one_shot_q || start_req)
						state_q <= ST_SAMPLE;
				end
				ST_SAMPLE: begin
					if (eng_start)
						state_q <= ST_CONVERT;
				end
				ST_CONVERT: begin
					if (eng_done)
						state_q <= one_shot_q ? ST_IDLE : ST_SAMPLE;
				end
			endcase
		end
	end

	// Sample phase length: 3 ticks track, 12 bits, no turnaround tick, 15-tick frame
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			smp_cnt_q <= '0;
			sample_q  <= 1'b0;
		end else begin
			if (state_q != ST_SAMPLE)
				smp_cnt_q <= '0;
			else if (tick)
				smp_cnt_q <= smp_cnt_q + `SMP_W'(1);
			sample_q <= state_q == ST_SAMPLE;
		end
	end

	// Input mode only changes between conversions
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			diff_sel_q <= ctrl_init[`CTRL_DIFF];
		else if (state_q != ST_SAMPLE && state_q != ST_CONVERT || conv_done)
			diff_sel_q <= diff_q;
	end

	// Result and done flag; a new result wins over a read in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			result_q <= '0;
			eof_q    <= 1'b0;
		end else begin
			if (conv_done)
				result_q <= eng_result;
			if (conv_done)
				eof_q <= 1'b1;
			else if (res_rd)
				eof_q <= 1'b0;
		end
	end

	// Sticky event bits, write one to clear, set wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			istat_q <= `EV_RESET;
		else if (hit(bus, `OFF_IRQ_STAT, 1'b1))
			istat_q <= (istat_q & ~bus.wdata[`EV_W-1:0]) | events;
		else
			istat_q <= istat_q | events;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			irq_q <= 1'b0;
		else
			irq_q <= |(istat_q & mask_q);
	end

	// Read port; unmapped offsets read zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= '0;
			if (bus.rd) begin
				unique case (bus.addr)
					`OFF_CTRL: begin
						rdata_q[`CTRL_EN]       <= en_q;
						rdata_q[`CTRL_ONE_SHOT] <= one_shot_q;
						rdata_q[`CTRL_DIFF]     <= diff_q;
					end
					`OFF_STATUS: begin
						rdata_q[`STAT_READY] <= ready_q;
						rdata_q[`STAT_BUSY]  <= state_q == ST_SAMPLE || state_q == ST_CONVERT;
						rdata_q[`STAT_DONE]  <= eof_q;
					end
					`OFF_RESULT:   rdata_q[`RES_W-1:0] <= result_q;
					`OFF_IRQ_STAT: rdata_q[`EV_W-1:0]  <= istat_q;
					`OFF_IRQ_MASK: rdata_q[`EV_W-1:0]  <= mask_q;
					`OFF_CLK_DIV:  rdata_q[`DIV_W-1:0] <= div_q;
					default: rdata_q <= '0;
				endcase
			end
		end
	end

	warmup_wait_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(ready_q) |-> $past(warm_cnt_q) == `WARM_CYC - `WARM_W'(1)
		&& $past(state_q) == ST_WARMUP) else $error("Ready before power-up wait");
	no_early_conv_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_SAMPLE |-> ready_q) else $error("Conversion while not ready");
	done_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		eof_q && !res_rd |=> eof_q) else $error("Done dropped without a read");
	done_set_a: assert property (@(posedge clk) disable iff (!resetn)
		conv_done |=> eof_q && result_q == $past(eng_result)) else $error("Done not set");
	read_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		res_rd && !conv_done |=> !eof_q) else $error("Read did not clear done");
	irq_source_a: assert property (@(posedge clk) disable iff (!resetn)
		conv_done && mask_q[`EV_DONE] && !bus.wr |=> ##1 irq_q) else $error("Done missed irq");
	single_stop_a: assert property (@(posedge clk) disable iff (!resetn)
		conv_done && one_shot_q && awake |=> state_q == ST_IDLE) else $error("One-shot rearmed");
	cont_rearm_a: assert property (@(posedge clk) disable iff (!resetn)
		conv_done && !one_shot_q && awake |=> state_q == ST_SAMPLE) else $error("No rearm");
	start_take_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_IDLE && awake && start_req |=> state_q == ST_SAMPLE)
		else $error("Start not taken");
	diff_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_CONVERT && !eng_done |=> $stable(diff_sel_q)) else $error("Input mode moved");
	cont_free_run_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_IDLE && awake && !one_shot_q |=> state_q == ST_SAMPLE)
		else $error("Continuous mode did not restart");
	idle_wait_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_IDLE && awake && one_shot_q && !start_req |=> state_q == ST_IDLE)
		else $error("Single mode started without a request");
	sof_start_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_IDLE && awake && sof && !sof_prev_q |=> state_q == ST_SAMPLE)
		else $error("Frame-start edge not taken");
	sleep_off_a: assert property (@(posedge clk) disable iff (!resetn)
		!awake |=> state_q == ST_OFF && !ready_q)
		else $error("Still ready while powered down");
	warm_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_WARMUP && awake && !ready_set |=> state_q == ST_WARMUP)
		else $error("Power-up wait cut short");
	ready_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		ready_set |=> ready_q && state_q == ST_IDLE)
		else $error("Ready not raised after the wait");
	conv_enter_a: assert property (@(posedge clk) disable iff (!resetn)
		eng_start && awake |=> state_q == ST_CONVERT && eng_busy)
		else $error("Search did not follow sampling");
	sample_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_SAMPLE |=> sample_q)
		else $error("Sample flag missing");
	sample_low_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q != ST_SAMPLE |=> !sample_q)
		else $error("Sample flag outside sampling");
	diff_follow_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_IDLE |=> diff_sel_q == $past(diff_q))
		else $error("Input mode not taken while idle");
	done_sticky_a: assert property (@(posedge clk) disable iff (!resetn)
		conv_done |=> istat_q[`EV_DONE])
		else $error("Done event not latched");
	overrun_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		overrun |=> istat_q[`EV_OVERRUN] && eof_q)
		else $error("Overrun event not latched");
	irq_on_a: assert property (@(posedge clk) disable iff (!resetn)
		|(istat_q & mask_q) |=> irq_q)
		else $error("Interrupt missing for unmasked event");
	irq_off_a: assert property (@(posedge clk) disable iff (!resetn)
		!(|(istat_q & mask_q)) |=> !irq_q)
		else $error("Interrupt with no unmasked event");
	mask_write_a: assert property (@(posedge clk) disable iff (!resetn)
		hit(bus, `OFF_IRQ_MASK, 1'b1) |=> mask_q == $past(bus.wdata[`EV_W-1:0]))
		else $error("Mask write lost");
	w1c_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		hit(bus, `OFF_IRQ_STAT, 1'b1) && events == `EV_RESET
		|=> (istat_q & $past(bus.wdata[`EV_W-1:0])) == `EV_RESET)
		else $error("Write one did not clear");
	status_read_a: assert property (@(posedge clk) disable iff (!resetn)
		bus.rd && bus.addr == `OFF_STATUS |=> rdata_q[`STAT_DONE] == $past(eof_q)
		&& rdata_q[`STAT_READY] == $past(ready_q))
		else $error("Status read wrong");
	result_read_a: assert property (@(posedge clk) disable iff (!resetn)
		hit(bus, `OFF_RESULT, 1'b0) |=> rdata_q[`RES_W-1:0] == $past(result_q)
		&& rdata_q[`DATA_W-1:`RES_W] == '0)
		else $error("Result read wrong");
	rdata_idle_a: assert property (@(posedge clk) disable iff (!resetn)
		!bus.rd |=> rdata_q == '0)
		else $error("Read data outside a read");
endmodule

// ==== tb/analog_dma_model.sv ====
// Far side model: analog input against the trial code, and a DMA reader.
// Assumes cmp_hi is sampled on conversion ticks and dma_ack is one clock long.
`timescale 1ns/1ps
`include "sar_ctrl_defines.svh"
module analog_dma_model
	import sar_ctrl_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [`RES_W-1:0] vin,
	input  wire logic [`RES_W-1:0] dac_code,
	input  wire logic              eof_q,
	input  wire logic              dma_en,
	input  wire logic [3:0]        ack_lat,
	output logic                   cmp_hi,
	output logic                   dma_ack,
	output int                     n_moved
);
	// Half-step offset, so a trial never equals the input exactly
	assign cmp_hi = ({vin, 1'b1} > {dac_code, 1'b0});
	initial begin
		dma_ack = 1'b0;
		n_moved = 0;
		forever begin
			@(posedge clk);
			if (dma_en && eof_q) begin
				repeat (ack_lat) @(posedge clk);
				dma_ack <= 1'b1;
				@(posedge clk);
				dma_ack <= 1'b0;
				n_moved++;
				// Done clears a clock after the read
				@(posedge clk);
			end
		end
	end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the converter control block.
// Assumes a 20 MHz clock and the far side model beside the block.
`timescale 1ns/1ps
`include "sar_ctrl_defines.svh"
module tb;
	import sar_ctrl_pkg::*;
	logic               clk;
	logic               resetn;
	reg_req_type        bus;
	logic [`DATA_W-1:0] rdata_q;
	logic               sof;
	logic               sleep;
	logic               cmp_hi;
	logic               dma_ack;
	logic [`RES_W-1:0]  dac_code;
	logic [`RES_W-1:0]  vin;
	logic               sample_q;
	logic               diff_sel_q;
	logic               eof_q;
	logic               irq_q;
	logic               dma_en;
	logic [3:0]         ack_lat;
	int                 n_moved;
	int                 n_mismatch;
	int                 comparisons;
	int                 cycles;

	sar_conv_ctrl sar_conv_ctrl_inst(.clk(clk), .resetn(resetn), .bus(bus), .rdata_q(rdata_q),
		.sof(sof), .sleep(sleep), .cmp_hi(cmp_hi), .dma_ack(dma_ack), .dac_code(dac_code),
		.sample_q(sample_q), .diff_sel_q(diff_sel_q), .eof_q(eof_q), .irq_q(irq_q));
	analog_dma_model analog_dma_model_inst(.clk(clk), .vin(vin), .dac_code(dac_code),
		.eof_q(eof_q), .dma_en(dma_en), .ack_lat(ack_lat), .cmp_hi(cmp_hi),
		.dma_ack(dma_ack), .n_moved(n_moved));

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk(what, exp, rdata_q & m);
	endtask

	task automatic wait_eof(input logic lvl);
		int i;
		i = 0;
		while (eof_q !== lvl && i < 300) begin
			@(posedge clk);
			#1 i++;
		end
		chk("eof_q", {31'h0, lvl}, {31'h0, eof_q});
	endtask

	task automatic t_reset();
		rchk("ctrl", `OFF_CTRL, 32'h4);
		rchk("clk_div", `OFF_CLK_DIV, 32'h2);
		rchk("mask", `OFF_IRQ_MASK, 32'h0);
		rchk("status", `OFF_STATUS, 32'h0);
		rchk("unmapped", 8'h18, 32'h0);
	endtask

	task automatic t_warmup();
		// Enable in single mode; no start until the wait is over
		wr(`OFF_CTRL, 32'h5);
		repeat (150) @(posedge clk);
		rchk("ready early", `OFF_STATUS, 32'h0, 32'h1);
		repeat (60) @(posedge clk);
		rchk("status idle", `OFF_STATUS, 32'h1);
		rchk("irq ready", `OFF_IRQ_STAT, 32'h2);
		wr(`OFF_IRQ_STAT, 32'h2);
		rchk("irq w1c", `OFF_IRQ_STAT, 32'h0);
	endtask

	task automatic t_sw_one();
		vin = 12'hA5C;
		wr(`OFF_IRQ_MASK, 32'h1);
		wr(`OFF_CTRL, 32'h7);
		wait_eof(1'b1);
		repeat (3) @(posedge clk);
		#1 chk("irq_q on", 32'h1, {31'h0, irq_q});
		rchk("done bit", `OFF_STATUS, 32'h4, 32'h4);
		chk("eof held", 32'h1, {31'h0, eof_q});
		rchk("result", `OFF_RESULT, 32'hA5C);
		chk("eof cleared", 32'h0, {31'h0, eof_q});
		@(posedge clk);
		#1 chk("eof stays low", 32'h0, {31'h0, eof_q});
		wr(`OFF_IRQ_STAT, 32'h1);
		repeat (3) @(posedge clk);
		#1 chk("irq_q off", 32'h0, {31'h0, irq_q});
		repeat (100) @(posedge clk);
		#1 chk("single only", 32'h0, {31'h0, eof_q});
	endtask

	task automatic t_sof();
		vin = 12'h3F1;
		wr(`OFF_IRQ_MASK, 32'h0);
		wr(`OFF_CTRL, 32'hD);
		repeat (2) @(posedge clk);
		#1 chk("diff_sel_q", 32'h1, {31'h0, diff_sel_q});
		@(posedge clk);
		sof <= 1'b1;
		@(posedge clk);
		sof <= 1'b0;
		@(posedge clk);
		#1 chk("sample_q", 32'h1, {31'h0, sample_q});
		wait_eof(1'b1);
		repeat (3) @(posedge clk);
		#1 chk("irq masked", 32'h0, {31'h0, irq_q});
		chk("sample_q idle", 32'h0, {31'h0, sample_q});
		dma_en = 1'b1;
		wait_eof(1'b0);
		dma_en = 1'b0;
		chk("dma moved", 32'd1, n_moved);
		rchk("irq sticky", `OFF_IRQ_STAT, 32'h1, 32'h1);
		rchk("sof result", `OFF_RESULT, 32'h3F1);
	endtask

	task automatic t_cont();
		int base;
		int i;
		base = n_moved;
		i = 0;
		vin = 12'h0FE;
		ack_lat = 4'd7;
		dma_en = 1'b1;
		wr(`OFF_CTRL, 32'h1);
		while (n_moved < base + 3 && i < 600) begin
			@(posedge clk);
			i++;
		end
		chk("cont moved", base + 3, n_moved);
		// With DMA held off, a later result lands on a set done flag
		dma_en = 1'b0;
		repeat (90) @(posedge clk);
		rchk("overrun", `OFF_IRQ_STAT, 32'h4, 32'h4);
		rchk("cont result", `OFF_RESULT, 32'h0FE);
		wr(`OFF_CTRL, 32'h4);
	endtask

	task automatic t_sleep();
		wr(`OFF_CTRL, 32'h5);
		repeat (220) @(posedge clk);
		sleep <= 1'b1;
		repeat (5) @(posedge clk);
		sleep <= 1'b0;
		repeat (100) @(posedge clk);
		rchk("wake early", `OFF_STATUS, 32'h0, 32'h1);
		repeat (120) @(posedge clk);
		rchk("wake ready", `OFF_STATUS, 32'h1, 32'h1);
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial begin
		n_mismatch = 0;
		comparisons = 0;
		cycles = 0;
		resetn = 1'b0;
		bus = '{addr: 8'h0, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
		sof = 1'b0;
		sleep = 1'b0;
		vin = 12'h0;
		dma_en = 1'b0;
		ack_lat = 4'd0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_warmup();
		t_sw_one();
		t_sof();
		t_cont();
		t_sleep();
		wrap_up();
	end
endmodule
